// ===== hw/tgt_bridge.v
// Target front end: write FIFO, deferred reads, byte-enable checks
//
// Contract
// - Repeats of a pending deferred read get Retry until data ready, then data+Disconnect.
// - All legal core reads are deferred; local window reads are answered directly.
// - A new deferred read is queued only while the write FIFO is empty.
// - Bit 30 of first local register shows write FIFO not empty.
// - Core memory reads accept any byte enables and return whole 16-bit words.
// - Core register read with a single byte in a word ends in Target-Abort.
// - Core register read of upper word only or no bytes returns zeros.
// - Deferred read with no bytes or register upper word completes in 3 link clocks.
// - Core memory is fetched 16 bits at a time; dword read is two accesses.
// - Dword memory read takes 13..16 link plus 11..17 core clocks.
// - Single word or register read takes 8..10 link plus 5..6 core clocks.
// - Core RAM contention adds bounded core clocks, less with fast access.
// - Fast host RAM access follows bit 14 of core configuration register 6.
// - Core writes go through the FIFO; local window writes update registers directly.
// - A 16-dword burst is accepted without waits when the FIFO has room.
// - Core memory write with a single byte in a word ends in Target-Abort.
// - Register write single byte aborts; only lower-word or dword writes change registers.
// - Memory Write and Invalidate behaves exactly like Memory Write.
// - FIFO not empty or read pending: core read gets Retry unless it repeats a ready pending read; nothing queued.
`timescale 1ns/10ps
`include "tgt_bridge_defines.vh"

module tgt_bridge #(
  parameter FIFO_AW = `WFIFO_AW
) (
  input wire core_clk,
  input wire rst_n,
  input wire pci_clk,
  input wire req,
  input wire req_write,
  input wire [3:0] req_cmd,
  input wire req_bar,
  input wire [16:0] req_addr,
  input wire [3:0] req_be_n,
  input wire [31:0] req_wdata,
  output wire ans_valid,
  output wire [1:0] ans_code,
  output wire [31:0] ans_rdata,
  output wire core_req,
  output wire core_we,
  output wire core_reg_sel,
  output wire [15:0] core_addr,
  output wire [15:0] core_wdata,
  input wire core_ack,
  input wire [15:0] core_rdata,
  input wire core_fast_cfg,
  output wire core_fast_access,
  output wire fifo_not_empty
);

  localparam DEPTH = 1 << FIFO_AW;
  localparam IN_W = 60;
  localparam FE_W = 52;
  localparam BF_W = 33;
  localparam S_IDLE = 3'h0;
  localparam S_PRE = 3'h1;
  localparam S_LO = 3'h2;
  localparam S_MID = 3'h3;
  localparam S_HI = 3'h4;
  localparam S_POST = 3'h5;
  localparam S_READY = 3'h6;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [IN_W-1:0] in_s1_ff;
  reg [IN_W-1:0] in_s2_ff;
  reg pclk_s1_ff;
  reg pclk_s2_ff;
  reg pclk_s3_ff;
  wire pci_rise;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      in_s1_ff <= {IN_W{1'b0}};
      in_s2_ff <= {IN_W{1'b0}};
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
      pclk_s3_ff <= 1'b0;
    end else begin
      in_s1_ff <= {req, req_write, req_cmd, req_bar, req_addr, req_be_n, req_wdata};
      in_s2_ff <= in_s1_ff;
      pclk_s1_ff <= pci_clk;
      pclk_s2_ff <= pclk_s1_ff;
      pclk_s3_ff <= pclk_s2_ff;
    end
  end

  assign pci_rise = pclk_s2_ff & ~pclk_s3_ff;

  wire r_req = in_s2_ff[59];
  wire [3:0] r_cmd = in_s2_ff[57:54];
  wire r_bar = in_s2_ff[53];
  wire [16:0] r_addr = in_s2_ff[52:36];
  wire [3:0] r_be_n = in_s2_ff[35:32];
  wire [31:0] r_wdata = in_s2_ff[31:0];

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire [3:0] be = ~r_be_n;
  wire lo_any = |be[1:0];
  wire hi_any = |be[3:2];
  wire single_byte = (be[1] ^ be[0]) | (be[3] ^ be[2]);
  wire is_local = r_bar && (r_addr[16:12] == 5'h00) &&
    (r_addr[11:0] >= `LOCAL_WIN_BASE) && (r_addr[11:0] <= `LOCAL_WIN_LAST);
  wire is_creg = r_bar && (r_addr[16:12] == 5'h00) && (r_addr[11:0] <= `CORE_REG_LAST);
  wire is_mem = ~r_bar;
  wire wr_cmd = (r_cmd == `CMD_MEM_WRITE) || (r_cmd == `CMD_MEM_WRITE_INV);
  wire rd_cmd = (r_cmd == `CMD_MEM_READ) || (r_cmd == `CMD_MEM_READ_MULT) ||
    (r_cmd == `CMD_MEM_READ_LINE);

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  reg ans_valid_ff;
  reg [1:0] ans_code_ff;
  reg [31:0] ans_rdata_ff;
  reg [31:0] local_ff [0:7];
  reg [FE_W-1:0] fifo_mem [0:DEPTH-1];
  reg [FIFO_AW-1:0] fifo_wp_ff;
  reg [FIFO_AW-1:0] fifo_rp_ff;
  reg [FIFO_AW:0] fifo_cnt_ff;
  reg half_ff;
  reg [BF_W-1:0] buf_ff [0:1];
  reg buf_wp_ff;
  reg buf_rp_ff;
  reg [1:0] buf_cnt_ff;
  reg [2:0] drr_state_ff;
  reg [2:0] drr_cnt_ff;
  reg drr_valid_ff;
  reg [16:0] drr_addr_ff;
  reg drr_bar_ff;
  reg [3:0] drr_cmd_ff;
  reg [3:0] drr_be_n_ff;
  reg drr_dbl_ff;
  reg drr_zero_ff;
  reg [31:0] drr_data_ff;
  reg fast_ff;

  wire fifo_full = fifo_cnt_ff[FIFO_AW];
  wire fifo_empty = (fifo_cnt_ff == {(FIFO_AW+1){1'b0}});
  wire buf_empty = (buf_cnt_ff == 2'h0);
  wire wr_pending = ~fifo_empty | ~buf_empty;
  wire drr_match = (r_addr == drr_addr_ff) && (r_bar == drr_bar_ff) &&
    (r_cmd == drr_cmd_ff) && (r_be_n == drr_be_n_ff);
  wire [31:0] local_rd = (r_addr[4:2] == 3'h0) ?
    {local_ff[0][31], wr_pending, local_ff[0][29:0]} : local_ff[r_addr[4:2]];

  // ----------------------------------------------------------------
  // Answer selection
  // ----------------------------------------------------------------
  reg take;
  reg [1:0] nxt_code;
  reg [31:0] nxt_rdata;
  reg do_push;
  reg do_queue;
  reg do_match;
  reg do_local_wr;

  always @* begin
    take = r_req & ~ans_valid_ff;
    nxt_code = `ANS_ABORT;
    nxt_rdata = 32'h00000000;
    do_push = 1'b0;
    do_queue = 1'b0;
    do_match = 1'b0;
    do_local_wr = 1'b0;
    if (is_local && (rd_cmd || wr_cmd)) begin
      nxt_code = `ANS_DONE;
      nxt_rdata = rd_cmd ? local_rd : 32'h00000000;
      do_local_wr = wr_cmd;
    end else if (is_mem || is_creg) begin
      if (wr_cmd) begin
        if (single_byte) begin
          nxt_code = `ANS_ABORT;
        end else if (fifo_full) begin
          nxt_code = `ANS_RETRY;
        end else begin
          nxt_code = `ANS_DONE;
          do_push = is_creg ? lo_any : (lo_any | hi_any);
        end
      end else if (rd_cmd) begin
        if (is_creg && single_byte) begin
          nxt_code = `ANS_ABORT;
        end else if (drr_valid_ff) begin
          if (drr_match && (drr_state_ff == S_READY)) begin
            nxt_code = `ANS_DISC_DATA;
            nxt_rdata = drr_data_ff;
            do_match = 1'b1;
          end else begin
            nxt_code = `ANS_RETRY;
          end
        end else begin
          nxt_code = `ANS_RETRY;
          do_queue = ~wr_pending;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer register and local registers
  // ----------------------------------------------------------------
  integer i;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      ans_valid_ff <= 1'b0;
      ans_code_ff <= `ANS_DONE;
      ans_rdata_ff <= 32'h00000000;
      for (i = 0; i < 8; i = i + 1) begin
        local_ff[i] <= `LOCAL_REG_RESET;
      end
    end else begin
      if (take) begin
        ans_valid_ff <= 1'b1;
        ans_code_ff <= nxt_code;
        ans_rdata_ff <= nxt_rdata;
      end else if (!r_req) begin
        ans_valid_ff <= 1'b0;
      end
      if (take && do_local_wr) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (be[i]) begin
            local_ff[r_addr[4:2]][8*i +: 8] <= r_wdata[8*i +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write FIFO and word splitter
  // ----------------------------------------------------------------
  wire [FE_W-1:0] head = fifo_mem[fifo_rp_ff];
  wire h_reg = head[51];
  wire [14:0] h_dw = head[50:36];
  wire h_lo = ~head[33] | ~head[32];
  wire h_hi = ~h_reg & (~head[35] | ~head[34]);
  wire cur_hi = half_ff | ~h_lo;
  wire drr_core = (drr_state_ff == S_LO) || (drr_state_ff == S_HI);
  // writes stay behind a started read
  wire hold_wr = drr_valid_ff & (drr_state_ff != S_READY);
  wire split_valid = ~fifo_empty & ~hold_wr;
  wire buf_in_ready = (buf_cnt_ff != 2'h2);
  wire split_fire = split_valid & buf_in_ready;
  wire split_pop = split_fire & (cur_hi | ~h_hi);
  wire push_fire = take & do_push;
  wire [15:0] split_addr = h_reg ? {10'h000, h_dw[5:0]} : {h_dw, cur_hi};
  wire [15:0] split_data = cur_hi ? head[31:16] : head[15:0];
  wire buf_out_valid = ~buf_empty & ~drr_core;
  wire buf_out_fire = buf_out_valid & core_ack;

  always @(posedge core_clk) begin
    if (push_fire) begin
      fifo_mem[fifo_wp_ff] <= {is_creg, r_addr[16:2], r_be_n, r_wdata};
    end
    if (split_fire) begin
      buf_ff[buf_wp_ff] <= {h_reg, split_addr, split_data};
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      fifo_wp_ff <= {FIFO_AW{1'b0}};
      fifo_rp_ff <= {FIFO_AW{1'b0}};
      fifo_cnt_ff <= {(FIFO_AW+1){1'b0}};
      half_ff <= 1'b0;
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (push_fire) begin
        fifo_wp_ff <= fifo_wp_ff + 1'b1;
      end
      if (split_pop) begin
        fifo_rp_ff <= fifo_rp_ff + 1'b1;
      end
      fifo_cnt_ff <= fifo_cnt_ff + {{FIFO_AW{1'b0}}, push_fire} -
        {{FIFO_AW{1'b0}}, split_pop};
      if (split_fire) begin
        half_ff <= ~split_pop;
        buf_wp_ff <= ~buf_wp_ff;
      end
      if (buf_out_fire) begin
        buf_rp_ff <= ~buf_rp_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, split_fire} - {1'b0, buf_out_fire};
    end
  end

  // ----------------------------------------------------------------
  // Deferred read engine
  // ----------------------------------------------------------------
  wire q_zero = ~(lo_any | hi_any) | (is_creg & ~lo_any);
  wire q_dbl = is_mem & lo_any & hi_any;
  wire d_lo = ~drr_be_n_ff[1] | ~drr_be_n_ff[0];
  wire [15:0] drr_waddr = (drr_bar_ff ? {10'h000, drr_addr_ff[7:2]} :
    {drr_addr_ff[16:2], (drr_state_ff == S_HI) | ~d_lo});
  wire cnt_done = pci_rise && (drr_cnt_ff == 3'h1);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      drr_state_ff <= S_IDLE;
      drr_cnt_ff <= 3'h0;
      drr_valid_ff <= 1'b0;
      drr_addr_ff <= 17'h00000;
      drr_bar_ff <= 1'b0;
      drr_cmd_ff <= 4'h0;
      drr_be_n_ff <= 4'hF;
      drr_dbl_ff <= 1'b0;
      drr_zero_ff <= 1'b0;
      drr_data_ff <= 32'h00000000;
    end else begin
      if (pci_rise && (drr_cnt_ff != 3'h0)) begin
        drr_cnt_ff <= drr_cnt_ff - 3'h1;
      end
      case (drr_state_ff)
        S_IDLE: begin
          if (take && do_queue) begin
            drr_valid_ff <= 1'b1;
            drr_addr_ff <= r_addr;
            drr_bar_ff <= r_bar;
            drr_cmd_ff <= r_cmd;
            drr_be_n_ff <= r_be_n;
            drr_dbl_ff <= q_dbl;
            drr_zero_ff <= q_zero;
            drr_data_ff <= 32'h00000000;
            // zero result after three link clocks
            drr_cnt_ff <= q_zero ? `DRR_ZERO_PCI : `DRR_PRE_PCI;
            drr_state_ff <= S_PRE;
          end
        end
        S_PRE: begin
          if (cnt_done) begin
            drr_state_ff <= drr_zero_ff ? S_READY : S_LO;
          end
        end
        S_LO: begin
          if (core_ack) begin
            // whole word even for one byte
            if (drr_bar_ff || d_lo) begin
              drr_data_ff[15:0] <= core_rdata;
            end else begin
              drr_data_ff[31:16] <= core_rdata;
            end
            drr_cnt_ff <= drr_dbl_ff ? `DRR_MID_PCI : `DRR_POST_PCI;
            drr_state_ff <= drr_dbl_ff ? S_MID : S_POST;
          end
        end
        S_MID: begin
          if (cnt_done) begin
            drr_state_ff <= S_HI;
          end
        end
        S_HI: begin
          if (core_ack) begin
            drr_data_ff[31:16] <= core_rdata;
            drr_cnt_ff <= `DRR_POST_PCI;
            drr_state_ff <= S_POST;
          end
        end
        S_POST: begin
          // single word finishes after post delay
          if (cnt_done) begin
            drr_state_ff <= S_READY;
          end
        end
        S_READY: begin
          if (take && do_match) begin
            drr_valid_ff <= 1'b0;
            drr_state_ff <= S_IDLE;
          end
        end
        default: begin
          drr_valid_ff <= 1'b0;
          drr_state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core port
  // ----------------------------------------------------------------
  wire [BF_W-1:0] buf_head = buf_ff[buf_rp_ff];

  always @(posedge core_clk) begin
    if (!rst_n) begin
      fast_ff <= 1'b0;
    end else begin
      fast_ff <= core_fast_cfg;
    end
  end

  assign core_req = drr_core | buf_out_valid;
  assign core_we = ~drr_core & buf_out_valid;
  assign core_reg_sel = drr_core ? drr_bar_ff : buf_head[32];
  assign core_addr = drr_core ? drr_waddr : buf_head[31:16];
  assign core_wdata = buf_head[15:0];
  assign core_fast_access = fast_ff;
  assign fifo_not_empty = wr_pending;
  assign ans_valid = ans_valid_ff;
  assign ans_code = ans_code_ff;
  assign ans_rdata = ans_rdata_ff;

endmodule

// ===== hw/tgt_bridge_defines.vh
// Constants for the deferred-read target bridge
`ifndef TGT_BRIDGE_DEFINES_VH
`define TGT_BRIDGE_DEFINES_VH

// ----------------------------------------------------------------
// Answer codes
// ----------------------------------------------------------------
`define ANS_DONE 2'h0
`define ANS_RETRY 2'h1
`define ANS_DISC_DATA 2'h2
`define ANS_ABORT 2'h3

// ----------------------------------------------------------------
// Bus commands
// ----------------------------------------------------------------
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_READ_MULT 4'hC
`define CMD_MEM_READ_LINE 4'hE
`define CMD_MEM_WRITE_INV 4'hF

// ----------------------------------------------------------------
// Address windows (second base region)
// ----------------------------------------------------------------
`define LOCAL_WIN_BASE 12'h800
`define LOCAL_WIN_LAST 12'h81C
`define CORE_REG_LAST 12'h0FC
`define LOCAL_FLAG_BIT 30
`define LOCAL_REG_RESET 32'h00000000

// ----------------------------------------------------------------
// Deferred read timing, in link clock periods
// ----------------------------------------------------------------
`define DRR_ZERO_PCI 3'h3
`define DRR_PRE_PCI 3'h4
`define DRR_MID_PCI 3'h5
`define DRR_POST_PCI 3'h4

// ----------------------------------------------------------------
// Write FIFO sizing
// ----------------------------------------------------------------
`define WFIFO_AW 4

`endif

// ===== tb/core_model.sv
// Terminal core model: RAM and registers behind a stallable acknowledge
`timescale 1ns/10ps
module core_model (
  input wire core_clk,
  input wire rst_n,
  input wire core_req,
  input wire core_we,
  input wire core_reg_sel,
  input wire [15:0] core_addr,
  input wire [15:0] core_wdata,
  input wire [3:0] stall,
  output reg core_ack,
  output reg [15:0] core_rdata
);
  reg [15:0] ram [0:255];
  reg [15:0] regs [0:63];
  reg [3:0] wait_ff;
  integer i;
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      ram[i] = 16'hC000 + i[15:0];
    end
    for (i = 0; i < 64; i = i + 1) begin
      regs[i] = 16'h5000 + i[15:0];
    end
    core_ack = 1'b0;
    core_rdata = 16'h0000;
    wait_ff = 4'h0;
  end
  // contention delay; stall F keeps the core busy
  always @(posedge core_clk) begin
    core_rdata <= ~core_rdata;
    if (!rst_n || !core_req || core_ack) begin
      wait_ff <= 4'h0;
      core_ack <= 1'b0;
    end else if (wait_ff >= stall && stall != 4'hF) begin
      core_ack <= 1'b1;
      core_rdata <= core_reg_sel ? regs[core_addr[5:0]] : ram[core_addr[7:0]];
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
    if (core_req && core_ack && core_we && core_reg_sel) begin
      regs[core_addr[5:0]] <= core_wdata;
    end
    if (core_req && core_ack && core_we && !core_reg_sel) begin
      ram[core_addr[7:0]] <= core_wdata;
    end
  end
endmodule

// ===== tb/tgt_bridge_props.sv
// Port checker for the target bridge
`timescale 1ns/10ps
`include "tgt_bridge_defines.vh"
module tgt_bridge_props (
  input wire core_clk,
  input wire rst_n,
  input wire req,
  input wire [3:0] req_cmd,
  input wire req_bar,
  input wire [16:0] req_addr,
  input wire [3:0] req_be_n,
  input wire ans_valid,
  input wire [1:0] ans_code,
  input wire [31:0] ans_rdata,
  input wire core_req,
  input wire core_we,
  input wire [15:0] core_addr,
  input wire core_ack,
  input wire core_fast_cfg,
  input wire core_fast_access,
  input wire fifo_not_empty
);
  wire rd = (req_cmd == `CMD_MEM_READ) || (req_cmd == `CMD_MEM_READ_MULT) ||
    (req_cmd == `CMD_MEM_READ_LINE);
  wire wr = (req_cmd == `CMD_MEM_WRITE) || (req_cmd == `CMD_MEM_WRITE_INV);
  wire one_b = (^req_be_n[1:0]) || (^req_be_n[3:2]);
  wire in_reg = req_bar && (req_addr <= 17'h000FC);
  wire in_loc = req_bar && (req_addr >= 17'h00800) && (req_addr <= 17'h0081C);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_ANS_HOLD: assert property (ans_valid && req |=> ans_valid && $stable(ans_code) &&
    $stable(ans_rdata)) else $error("answer changed while request held");
  AST_LOCAL_DIRECT: assert property ($rose(ans_valid) && in_loc && rd |->
    ans_code == `ANS_DONE) else $error("local read not answered directly");
  AST_FIFO_FLAG: assert property ($rose(ans_valid) && in_loc && rd && req_addr[4:0] == 5'h00 &&
    $stable(fifo_not_empty) && $past(fifo_not_empty, 2) == fifo_not_empty |->
    ans_rdata[30] == fifo_not_empty) else $error("fifo flag bit wrong");
  AST_REG_RD_ABORT: assert property ($rose(ans_valid) && in_reg && rd && one_b |->
    ans_code == `ANS_ABORT) else $error("single byte register read not aborted");
  AST_REG_ZERO: assert property ($rose(ans_valid) && in_reg && rd && req_be_n[1:0] == 2'b11 &&
    ans_code == `ANS_DISC_DATA |-> ans_rdata == 32'h00000000) else $error("upper read not zero");
  AST_WR_ABORT: assert property ($rose(ans_valid) && (!req_bar || in_reg) && wr && one_b |->
    ans_code == `ANS_ABORT) else $error("single byte write not aborted");
  AST_CORE_WR_FIFO: assert property (core_req && core_we |-> fifo_not_empty)
    else $error("core write without queued entry");
  AST_CORE_HOLD: assert property (core_req && !core_ack |=> core_req && $stable(core_addr) &&
    $stable(core_we)) else $error("core request dropped before acknowledge");
  AST_FAST_COPY: assert property ($changed(core_fast_cfg) |=>
    core_fast_access == $past(core_fast_cfg)) else $error("fast access not forwarded");
endmodule

bind tgt_bridge tgt_bridge_props chk_u (.core_clk(core_clk), .rst_n(rst_n), .req(req),
  .req_cmd(req_cmd), .req_bar(req_bar), .req_addr(req_addr), .req_be_n(req_be_n),
  .ans_valid(ans_valid), .ans_code(ans_code), .ans_rdata(ans_rdata), .core_req(core_req),
  .core_we(core_we), .core_addr(core_addr), .core_ack(core_ack),
  .core_fast_cfg(core_fast_cfg), .core_fast_access(core_fast_access),
  .fifo_not_empty(fifo_not_empty));

// ===== tb/tgt_bridge_tb_top.sv
// Self-checking bench for the target bridge
`timescale 1ns/10ps
`include "tgt_bridge_defines.vh"
module tgt_bridge_tb_top;
  reg core_clk = 1'b0;
  reg pci_clk = 1'b0;
  reg rst_n = 1'b0;
  reg req = 1'b0;
  reg req_write = 1'b0;
  reg [3:0] req_cmd = 4'h0;
  reg req_bar = 1'b0;
  reg [16:0] req_addr = 17'h00000;
  reg [3:0] req_be_n = 4'h0;
  reg [31:0] req_wdata = 32'h00000000;
  reg core_fast_cfg = 1'b0;
  reg [3:0] stall = 4'h0;
  wire ans_valid;
  wire [1:0] ans_code;
  wire [31:0] ans_rdata;
  wire core_req;
  wire core_we;
  wire core_reg_sel;
  wire [15:0] core_addr;
  wire [15:0] core_wdata;
  wire core_ack;
  wire [15:0] core_rdata;
  wire core_fast_access;
  wire fifo_not_empty;
  integer error_cnt = 0;
  integer samples_checked = 0;
  reg [1:0] code_s;
  reg [31:0] data_s;
  realtime t_ans;
  always #20 core_clk = ~core_clk;
  always #160 pci_clk = ~pci_clk;
  tgt_bridge #(.FIFO_AW(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .pci_clk(pci_clk),
    .req(req), .req_write(req_write), .req_cmd(req_cmd), .req_bar(req_bar),
    .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata), .ans_valid(ans_valid),
    .ans_code(ans_code), .ans_rdata(ans_rdata), .core_req(core_req), .core_we(core_we),
    .core_reg_sel(core_reg_sel), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_ack(core_ack), .core_rdata(core_rdata), .core_fast_cfg(core_fast_cfg),
    .core_fast_access(core_fast_access), .fifo_not_empty(fifo_not_empty));
  core_model core_u (.core_clk(core_clk), .rst_n(rst_n), .core_req(core_req),
    .core_we(core_we), .core_reg_sel(core_reg_sel), .core_addr(core_addr),
    .core_wdata(core_wdata), .stall(stall), .core_ack(core_ack), .core_rdata(core_rdata));
  task chk_code(input string nm, input [1:0] exp, input [1:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task chk_data(input string nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Four-phase request, fields settle one cycle before req
  task xfer(input [3:0] cmd, input bar, input [16:0] addr, input [3:0] be, input [31:0] wd);
    integer n;
    begin
      @(negedge core_clk);
      req_cmd = cmd;
      req_write = cmd[0];
      req_bar = bar;
      req_addr = addr;
      req_be_n = be;
      req_wdata = wd;
      @(negedge core_clk);
      req = 1'b1;
      n = 0;
      while (ans_valid !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (n >= 40) begin
        error_cnt = error_cnt + 1;
        $display("ERROR ans_valid expected 1 seen %b", ans_valid);
      end
      code_s = ans_code;
      data_s = ans_rdata;
      t_ans = $realtime;
      req = 1'b0;
      while (ans_valid !== 1'b0 && n < 80) begin
        @(negedge core_clk);
        n = n + 1;
      end
    end
  endtask
  task wait_empty;
    integer n;
    begin
      n = 0;
      while (fifo_not_empty !== 1'b0 && n < 4000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk_data("drain", 32'h0, {31'h0, fifo_not_empty});
    end
  endtask
  // Deferred read: queue, early repeat, repeat at the upper time bound
  task dread(input [3:0] cmd, input bar, input [16:0] addr, input [3:0] be,
    input realtime early, input realtime late, input [31:0] exp, input [31:0] msk);
    realtime t0;
    begin
      xfer(cmd, bar, addr, be, 32'h0);
      chk_code("queue", `ANS_RETRY, code_s);
      t0 = t_ans;
      #(t0 + early - $realtime);
      xfer(cmd, bar, addr, be, 32'h0);
      chk_code("early", `ANS_RETRY, code_s);
      #(t0 + late - $realtime);
      xfer(cmd, bar, addr, be, 32'h0);
      chk_code("ready", `ANS_DISC_DATA, code_s);
      chk_data("rdata", exp, data_s & msk);
    end
  endtask
  task s_local;
    begin
      xfer(`CMD_MEM_WRITE, 1'b1, 17'h00804, 4'h0, 32'h12345678);
      chk_code("loc_wr", `ANS_DONE, code_s);
      xfer(`CMD_MEM_READ, 1'b1, 17'h00804, 4'h0, 32'h0);
      chk_code("loc_rd", `ANS_DONE, code_s);
      chk_data("loc_data", 32'h12345678, data_s);
      xfer(`CMD_MEM_READ, 1'b1, 17'h00800, 4'h0, 32'h0);
      chk_data("flag_idle", 32'h0, data_s & 32'h40000000);
      core_fast_cfg = 1'b1;
      repeat (3) @(negedge core_clk);
      chk_data("fast", 32'h1, {31'h0, core_fast_access});
    end
  endtask
  task s_abort;
    begin
      xfer(`CMD_MEM_WRITE, 1'b0, 17'h00100, 4'hE, 32'h0);
      chk_code("wr_mem_byte", `ANS_ABORT, code_s);
      xfer(`CMD_MEM_WRITE_INV, 1'b1, 17'h00008, 4'h7, 32'h0);
      chk_code("wr_reg_byte", `ANS_ABORT, code_s);
      xfer(`CMD_MEM_READ_LINE, 1'b1, 17'h00008, 4'hD, 32'h0);
      chk_code("rd_reg_byte", `ANS_ABORT, code_s);
      chk_data("no_entry", 32'h0, {31'h0, fifo_not_empty});
    end
  endtask
  task s_reg;
    begin
      xfer(`CMD_MEM_WRITE, 1'b1, 17'h00010, 4'h0, 32'hFFFF5A5A);
      chk_code("reg_wr", `ANS_DONE, code_s);
      xfer(`CMD_MEM_WRITE, 1'b1, 17'h00010, 4'h3, 32'h11112222);
      chk_code("reg_up_wr", `ANS_DONE, code_s);
      wait_empty;
      dread(`CMD_MEM_READ, 1'b1, 17'h00010, 4'h0, 1920, 3440, 32'h5A5A, 32'hFFFF);
      dread(`CMD_MEM_READ, 1'b1, 17'h00010, 4'h3, 320, 960, 32'h0, 32'hFFFFFFFF);
      dread(`CMD_MEM_READ, 1'b0, 17'h00020, 4'hF, 320, 960, 32'h0, 32'hFFFFFFFF);
      dread(`CMD_MEM_READ, 1'b0, 17'h00020, 4'hE, 1920, 3440, 32'hC010, 32'hFFFF);
      xfer(`CMD_MEM_WRITE, 1'b0, 17'h00028, 4'hC, 32'hBEEF1234);
      chk_code("lo_wr", `ANS_DONE, code_s);
      wait_empty;
      dread(`CMD_MEM_READ, 1'b0, 17'h00028, 4'h0, 3520, 5800, 32'hC0151234, 32'hFFFFFFFF);
    end
  endtask
  task s_burst;
    integer i;
    reg refused;
    begin
      stall = 4'hF;
      refused = 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
        if (!refused) begin
          xfer(i[0] ? `CMD_MEM_WRITE_INV : `CMD_MEM_WRITE, 1'b0, 17'h00080 + {i[14:0], 2'b00},
            4'h0, 32'hA5000000 + i);
          if (i < 16) chk_code("burst", `ANS_DONE, code_s);
          refused = (code_s === `ANS_RETRY);
        end
      end
      chk_data("full", 32'h1, {31'h0, refused});
      xfer(`CMD_MEM_READ, 1'b1, 17'h00800, 4'h0, 32'h0);
      chk_data("flag_busy", 32'h40000000, data_s & 32'h40000000);
      xfer(`CMD_MEM_READ, 1'b0, 17'h00080, 4'h0, 32'h0);
      chk_code("rd_busy", `ANS_RETRY, code_s);
      stall = 4'h2;
      wait_empty;
      dread(`CMD_MEM_READ, 1'b0, 17'h00084, 4'h0, 3520, 5800, 32'hA5000001, 32'hFFFFFFFF);
    end
  endtask
  task s_mismatch;
    begin
      stall = 4'h0;
      xfer(`CMD_MEM_READ, 1'b0, 17'h00040, 4'h0, 32'h0);
      chk_code("queue_a", `ANS_RETRY, code_s);
      #6000;
      xfer(`CMD_MEM_READ_MULT, 1'b0, 17'h00040, 4'h0, 32'h0);
      chk_code("cmd_diff", `ANS_RETRY, code_s);
      xfer(`CMD_MEM_READ, 1'b0, 17'h00044, 4'h0, 32'h0);
      chk_code("addr_diff", `ANS_RETRY, code_s);
      xfer(`CMD_MEM_READ, 1'b0, 17'h00040, 4'h0, 32'h0);
      chk_code("match", `ANS_DISC_DATA, code_s);
      chk_data("match_data", 32'hC021C020, data_s);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    #1000000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    s_local;
    s_abort;
    s_reg;
    s_burst;
    s_mismatch;
    give_verdict;
  end
endmodule
